// file: src/rfs_pkg.sv
// Shared constants and carrier types for the radio frame status and sync logic.
// Assumes one 250 MHz clock; symbol strobes arrive from the modem as enables.
package rfs_pkg;
  localparam int RX_DEPTH = 128;
  localparam int CNT_W    = 8;
  localparam logic [15:0] SYNC_WORD_RST   = 16'ha70f;
  localparam logic [3:0]  PREAMBLE_LEN_RST = 4'h6;
  localparam logic [3:0]  SYM_DONT_CARE   = 4'hf;
  localparam logic [3:0]  SYM_ZERO        = 4'h0;
  localparam logic [4:0]  CORRELATION_THRESHOLD_ADVISED = 5'h14;
  localparam logic [6:0]  THRESHOLD_RST   = 7'h40;
  localparam logic [6:0]  LEN_MAX         = 7'h7f;
  localparam logic [1:0]  DBG_SEL_DELIM   = 2'h0;
  localparam logic [1:0]  DBG_SEL_NONEMPTY = 2'h1;
  localparam logic [1:0]  DBG_SEL_THRESH  = 2'h2;
  localparam logic [1:0]  DBG_SEL_CLEAR   = 2'h3;

  typedef enum logic [2:0] {TX_IDLE, TX_PREAMBLE, TX_SYNC, TX_LEN, TX_BODY} rfs_tx_e;
  typedef enum logic [1:0] {RX_HUNT, RX_LEN, RX_BODY} rfs_rx_e;

  // Debug pin routing: one select and one polarity bit per pin
  typedef struct packed {
    logic [3:0][1:0] sel;
    logic [3:0]      invert;
  } rfs_dbg_cfg_s;

  // Status bits presented to software
  typedef struct packed {
    logic delim;
    logic nonempty;
    logic threshold;
    logic clear;
  } rfs_status_s;
endpackage

// file: src/rfs_rx_store.sv
// Receive byte store with overflow lockout, count and threshold status.
// Assumes writes come from the frame logic and reads from the core or DMA.
`timescale 1ns/100ps
module rfs_rx_store #(
  parameter int DEPTH = rfs_pkg::RX_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       flush,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       frame_end,
  input  wire logic       rd_en,
  input  wire logic [6:0] threshold,
  output logic [7:0]      rd_data,
  output logic            nonempty,
  output logic            thresh_st,
  output logic            overflow,
  output logic [7:0]      count
);
  typedef struct packed {
    logic [6:0] wp;
    logic [6:0] rp;
    logic [7:0] cnt;
    logic       locked;
    logic       ovf;
    logic       frame_hold;
  } rfs_st_s;

  rfs_st_s    st_reg;
  rfs_st_s    st_next;
  logic [7:0] mem [DEPTH];
  logic       do_wr;
  logic       do_rd;

  assign do_rd = rd_en && (st_reg.cnt != 8'h00);
  // Full store or lockout discards the byte
  assign do_wr = wr_en && !st_reg.locked && (st_reg.cnt < 8'(DEPTH));

  // Next-state for pointers, count and lockout
  always_comb begin
    st_next     = st_reg;
    st_next.ovf = 1'b0;
    if (do_wr) st_next.wp = st_reg.wp + 7'h01;
    if (do_rd) st_next.rp = st_reg.rp + 7'h01;
    st_next.cnt = st_reg.cnt + {7'h00, do_wr} - {7'h00, do_rd};
    if (wr_en && !st_reg.locked && st_reg.cnt >= 8'(DEPTH)) begin
      st_next.locked = 1'b1;
      st_next.ovf    = 1'b1;
    end
    // A frame end in the same cycle as a read keeps the hold set, unless the store is locked out
    if (do_rd) st_next.frame_hold = 1'b0;
    if (frame_end && (do_wr || !st_reg.locked)) st_next.frame_hold = 1'b1;
    if (flush) begin
      st_next = '0;
    end
  end

  // State and storage; stored bytes are never altered on overflow
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
      if (do_wr && !flush) mem[st_reg.wp] <= wr_data;
    end
  end

  assign rd_data   = mem[st_reg.rp];
  assign count     = st_reg.cnt;
  assign overflow  = st_reg.ovf;
  // Lockout forces nonempty low and threshold high
  assign nonempty  = !st_reg.locked && (st_reg.cnt != 8'h00);
  assign thresh_st = st_reg.locked || (st_reg.cnt > {1'b0, threshold})
                     || st_reg.frame_hold;
endmodule

// file: src/rfs_top.sv
// Frame status, sync header and length handling of the packet radio.
// Assumes a modem that gives one symbol strobe per 4-bit symbol each way.
`timescale 1ns/100ps
module rfs_top #(
  parameter int DEPTH = rfs_pkg::RX_DEPTH
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 SYS_RST,
  input  wire logic                 CLK_EN,
  input  wire logic                 RX_SYM_VALID,
  input  wire logic [3:0]           RX_SYM,
  input  wire logic                 TX_SYM_READY,
  input  wire logic                 TX_START,
  input  wire logic                 TX_DATA_VALID,
  input  wire logic [7:0]           TX_DATA,
  input  wire logic                 RX_FLUSH_STROBE,
  input  wire logic                 RX_READ,
  input  wire logic                 CHANNEL_CLEAR,
  input  wire logic                 ERR_IRQ_ENABLE,
  input  wire logic                 DELIM_FLAG_CLEAR,
  input  wire logic                 THRESH_FLAG_CLEAR,
  input  wire logic [15:0]          SYNC_WORD,
  input  wire logic                 SYNC_WORD_LOAD,
  input  wire logic [3:0]           PREAMBLE_LENGTH,
  input  wire logic                 PREAMBLE_LOAD,
  input  wire logic [6:0]           RX_THRESHOLD_LEVEL,
  input  wire rfs_pkg::rfs_dbg_cfg_s DBG_CFG,
  output logic [7:0]                RX_DATA,
  output logic [7:0]                RX_COUNT,
  output logic                      TX_DATA_TAKE,
  output logic                      TX_SYM_VALID,
  output logic [3:0]                TX_SYM,
  output rfs_pkg::rfs_status_s      RADIO_STATUS,
  output logic                      FRAME_DELIM_FLAG,
  output logic                      RX_THRESHOLD_FLAG,
  output logic                      RADIO_IRQ,
  output logic                      RADIO_ERROR_IRQ,
  output logic [3:0]                DBG_PINS
);
  typedef struct packed {
    rfs_pkg::rfs_tx_e     tx_st;
    rfs_pkg::rfs_rx_e     rx_st;
    logic [15:0]          sync;
    logic [3:0]           pre_len;
    logic [3:0]           tx_cnt;
    logic                 tx_nib;
    logic [7:0]           tx_byte;
    logic [6:0]           tx_left;
    logic [15:0]          rx_shift;
    logic [4:0]           rx_hist;
    logic                 rx_nib;
    logic [3:0]           rx_lo;
    logic [6:0]           rx_left;
    logic                 rx_delim;
    logic                 tx_delim;
    logic                 dflag;
    logic                 tflag;
    logic                 err;
    logic [7:0]           rxd;
    logic [7:0]           rxc;
    logic                 take;
    logic                 sym_v;
    logic [3:0]           sym;
    rfs_pkg::rfs_status_s status;
    logic [3:0]           dbg;
  } rfs_top_s;

  rfs_top_s   st_reg;
  rfs_top_s   st_next;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       frame_end;
  logic [7:0] rd_data;
  logic       nonempty;
  logic       thresh_st;
  logic       overflow;
  logic [7:0] count;
  logic       rx_flush;

  // Sync match: leading (low-order, first sent) don't-care symbols ignored, others must match
  function automatic logic sync_match(input logic [15:0] word, input logic [15:0] got);
    logic skip;
    logic ok;
    skip = 1'b1;
    ok   = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (skip && word[4*i +: 4] == rfs_pkg::SYM_DONT_CARE) begin
        ok = ok;
      end else begin
        skip = 1'b0;
        if (word[4*i +: 4] != got[4*(3-i) +: 4]) ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Debug pin source decode
  function automatic logic dbg_pick(input logic [1:0] sel, input rfs_pkg::rfs_status_s s);
    logic v;
    v = 1'b0;
    unique case (sel)
      rfs_pkg::DBG_SEL_DELIM:    v = s.delim;
      rfs_pkg::DBG_SEL_NONEMPTY: v = s.nonempty;
      rfs_pkg::DBG_SEL_THRESH:   v = s.threshold;
      rfs_pkg::DBG_SEL_CLEAR:    v = s.clear;
    endcase
    return v;
  endfunction

  assign rx_flush = RX_FLUSH_STROBE && CLK_EN;

  rfs_rx_store #(
    .DEPTH (DEPTH)
  ) u_store (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .ce        (CLK_EN),
    .flush     (RX_FLUSH_STROBE),
    .wr_en     (wr_en),
    .wr_data   (wr_data),
    .frame_end (frame_end),
    .rd_en     (RX_READ),
    .threshold (RX_THRESHOLD_LEVEL),
    .rd_data   (rd_data),
    .nonempty  (nonempty),
    .thresh_st (thresh_st),
    .overflow  (overflow),
    .count     (count)
  );

  // Receive framing, transmit sequencing, flags and debug routing
  always_comb begin
    logic [15:0] shifted;
    logic [7:0]  rx_byte;
    logic        underflow;
    logic        tx_done;
    shifted   = {st_reg.rx_shift[11:0], RX_SYM};
    rx_byte   = {RX_SYM, st_reg.rx_lo};
    underflow = 1'b0;
    tx_done   = 1'b0;
    wr_en     = 1'b0;
    wr_data   = rx_byte;
    frame_end = 1'b0;
    st_next   = st_reg;
    st_next.take  = 1'b0;
    st_next.sym_v = 1'b0;
    st_next.err   = 1'b0;
    if (SYNC_WORD_LOAD) st_next.sync = SYNC_WORD;
    // Preamble length is used by the transmitter only
    if (PREAMBLE_LOAD) st_next.pre_len = PREAMBLE_LENGTH;
    // Receive path; delimiter only aligns bytes and is not stored
    if (RX_SYM_VALID) begin
      unique case (st_reg.rx_st)
        rfs_pkg::RX_HUNT: begin
          st_next.rx_shift = shifted;
          st_next.rx_hist  = {st_reg.rx_hist[3:0], RX_SYM == rfs_pkg::SYM_ZERO};
          // Lock to zero symbols, then the sync word
          if (st_reg.rx_hist[4:3] == 2'b11 && sync_match(st_reg.sync, shifted)) begin
            st_next.rx_st    = rfs_pkg::RX_LEN;
            st_next.rx_nib   = 1'b0;
            st_next.rx_delim = 1'b1;
            st_next.dflag    = 1'b1;
          end
        end
        rfs_pkg::RX_LEN: begin
          st_next.rx_nib = !st_reg.rx_nib;
          st_next.rx_lo  = RX_SYM;
          if (st_reg.rx_nib) begin
            wr_en           = 1'b1;
            st_next.rx_left = rx_byte[6:0];
            st_next.rx_st   = rfs_pkg::RX_BODY;
            if (rx_byte[6:0] == 7'h00) begin
              frame_end        = 1'b1;
              st_next.rx_st    = rfs_pkg::RX_HUNT;
              st_next.rx_delim = 1'b0;
            end
          end
        end
        rfs_pkg::RX_BODY: begin
          st_next.rx_nib = !st_reg.rx_nib;
          st_next.rx_lo  = RX_SYM;
          if (st_reg.rx_nib) begin
            wr_en           = 1'b1;
            st_next.rx_left = st_reg.rx_left - 7'h01;
            if (st_reg.rx_left == 7'h01) begin
              frame_end        = 1'b1;
              st_next.tflag    = 1'b1;
              st_next.rx_st    = rfs_pkg::RX_HUNT;
              st_next.rx_delim = 1'b0;
              st_next.rx_hist  = '0;
            end
          end
        end
        default: st_next.rx_st = rfs_pkg::RX_HUNT;
      endcase
    end
    if (rx_flush) begin
      st_next.rx_st    = rfs_pkg::RX_HUNT;
      st_next.rx_delim = 1'b0;
    end
    // Transmit: preamble, sync word, length, then body
    unique case (st_reg.tx_st)
      rfs_pkg::TX_IDLE: begin
        if (TX_START) begin
          st_next.tx_st  = rfs_pkg::TX_PREAMBLE;
          st_next.tx_cnt = 4'h0;
        end
      end
      rfs_pkg::TX_PREAMBLE: begin
        if (TX_SYM_READY) begin
          st_next.sym_v  = 1'b1;
          st_next.sym    = rfs_pkg::SYM_ZERO;
          st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
          if (st_reg.tx_cnt + 4'h1 >= st_reg.pre_len) begin
            st_next.tx_st  = rfs_pkg::TX_SYNC;
            st_next.tx_cnt = 4'h0;
          end
        end
      end
      rfs_pkg::TX_SYNC: begin
        if (TX_SYM_READY) begin
          // Sync word goes low symbol first, four symbols of the loaded word
          st_next.sym_v  = 1'b1;
          st_next.sym    = st_reg.sync[4*st_reg.tx_cnt[1:0] +: 4];
          st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
          if (st_reg.tx_cnt == 4'h3) begin
            st_next.tx_st    = rfs_pkg::TX_LEN;
            st_next.tx_delim = 1'b1;
            st_next.dflag    = 1'b1;
            st_next.tx_nib   = 1'b0;
          end
        end
      end
      rfs_pkg::TX_LEN, rfs_pkg::TX_BODY: begin
        if (TX_SYM_READY) begin
          if (!st_reg.tx_nib) begin
            if (TX_DATA_VALID) begin
              st_next.take    = 1'b1;
              st_next.tx_byte = TX_DATA;
              st_next.sym_v   = 1'b1;
              st_next.sym     = TX_DATA[3:0];
              st_next.tx_nib  = 1'b1;
              if (st_reg.tx_st == rfs_pkg::TX_LEN) begin
                st_next.tx_left = TX_DATA[6:0];
                st_next.tx_st   = rfs_pkg::TX_BODY;
              end else begin
                st_next.tx_left = st_reg.tx_left - 7'h01;
              end
            end else begin
              underflow = 1'b1;
            end
          end else begin
            st_next.sym_v  = 1'b1;
            st_next.sym    = st_reg.tx_byte[7:4];
            st_next.tx_nib = 1'b0;
            tx_done = (st_reg.tx_st == rfs_pkg::TX_BODY) && (st_reg.tx_left == 7'h00);
          end
        end
      end
      default: st_next.tx_st = rfs_pkg::TX_IDLE;
    endcase
    if (tx_done || underflow) begin
      st_next.tx_st    = rfs_pkg::TX_IDLE;
      st_next.tx_delim = 1'b0;
      st_next.dflag    = 1'b0;
    end
    // Error irq for overflow or underflow when enabled
    st_next.err = ERR_IRQ_ENABLE && (overflow || underflow);
    // Software clears flags; a new event wins over the clear only while its flag is low, a threshold rise always
    if (DELIM_FLAG_CLEAR && !(st_next.dflag && !st_reg.dflag)) st_next.dflag = 1'b0;
    if (THRESH_FLAG_CLEAR && !(st_next.tflag && !st_reg.tflag)) st_next.tflag = 1'b0;
    if (thresh_st && !st_reg.status.threshold) st_next.tflag = 1'b1;
    st_next.rxd = rd_data;
    st_next.rxc = count;
    // Store status tracks receive side only, delim covers both
    st_next.status.delim     = st_next.rx_delim || st_next.tx_delim;
    st_next.status.nonempty  = nonempty;
    st_next.status.threshold = thresh_st;
    st_next.status.clear     = CHANNEL_CLEAR;
    for (int p = 0; p < 4; p++) begin
      st_next.dbg[p] = dbg_pick(DBG_CFG.sel[p], st_next.status) ^ DBG_CFG.invert[p];
    end
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg         <= '0;
      st_reg.tx_st   <= rfs_pkg::TX_IDLE;
      st_reg.rx_st   <= rfs_pkg::RX_HUNT;
      st_reg.sync    <= rfs_pkg::SYNC_WORD_RST;
      st_reg.pre_len <= rfs_pkg::PREAMBLE_LEN_RST;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  assign RX_DATA           = st_reg.rxd;
  assign RX_COUNT          = st_reg.rxc;
  assign TX_DATA_TAKE      = st_reg.take;
  assign TX_SYM_VALID      = st_reg.sym_v;
  assign TX_SYM            = st_reg.sym;
  assign RADIO_STATUS      = st_reg.status;
  assign FRAME_DELIM_FLAG  = st_reg.dflag;
  assign RX_THRESHOLD_FLAG = st_reg.tflag;
  assign RADIO_IRQ         = st_reg.dflag || st_reg.tflag;
  assign RADIO_ERROR_IRQ   = st_reg.err;
  assign DBG_PINS          = st_reg.dbg;
endmodule

// file: bench/rfs_top_monitor.sv
// Checker of the frame status block as seen at its ports.
// Assumes it is bound to rfs_top and shares its single clock and reset.
`timescale 1ns/100ps
module rfs_top_monitor (
  input wire logic                  REF_CLK,
  input wire logic                  SYS_RST,
  input wire logic                  CLK_EN,
  input wire logic                  ERR_IRQ_ENABLE,
  input wire logic                  RX_FLUSH_STROBE,
  input wire logic [6:0]            RX_THRESHOLD_LEVEL,
  input wire rfs_pkg::rfs_dbg_cfg_s DBG_CFG,
  input wire logic [7:0]            RX_COUNT,
  input wire rfs_pkg::rfs_status_s  RADIO_STATUS,
  input wire logic                  FRAME_DELIM_FLAG,
  input wire logic                  RX_THRESHOLD_FLAG,
  input wire logic                  RADIO_IRQ,
  input wire logic                  RADIO_ERROR_IRQ,
  input wire logic [3:0]            DBG_PINS
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  a_count_at_most: assert property (RX_COUNT <= 8'h80)
    else $error("store count above capacity");
  a_err_irq_gated: assert property (RADIO_ERROR_IRQ |-> $past(ERR_IRQ_ENABLE))
    else $error("error irq while disabled");
  a_empty_no_data: assert property ((RX_COUNT == 8'h00)[*3] |-> !RADIO_STATUS.nonempty)
    else $error("nonempty with empty store");
  a_thr_above_level: assert property ((({1'b0, RX_THRESHOLD_LEVEL} < RX_COUNT)
    && $stable(RX_THRESHOLD_LEVEL))[*3] |-> RADIO_STATUS.threshold)
    else $error("threshold status low above level");
  a_thr_flag_set: assert property ($rose(RADIO_STATUS.threshold) |-> ##[0:2] RX_THRESHOLD_FLAG)
    else $error("threshold flag not set");
  a_delim_irq_req: assert property ($rose(FRAME_DELIM_FLAG) |-> ##[0:1] RADIO_IRQ)
    else $error("delimiter flag without irq");
  a_thr_irq_req: assert property ($rose(RX_THRESHOLD_FLAG) |-> ##[0:1] RADIO_IRQ)
    else $error("threshold flag without irq");
  a_delim_status_on: assert property ($rose(FRAME_DELIM_FLAG) |-> ##[0:1] RADIO_STATUS.delim)
    else $error("delimiter status not active");
  a_flush_empties: assert property (RX_FLUSH_STROBE && CLK_EN |-> ##[1:3] (RX_COUNT == 8'h00))
    else $error("flush left bytes in store");
  a_dbg_pin_route: assert property (($stable(DBG_CFG) && $stable(RADIO_STATUS))[*3]
    |-> DBG_PINS[0] == (RADIO_STATUS[3 - DBG_CFG.sel[0]] ^ DBG_CFG.invert[0]))
    else $error("debug pin routing wrong");
endmodule
bind rfs_top rfs_top_monitor i_mon (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .ERR_IRQ_ENABLE(ERR_IRQ_ENABLE), .RX_FLUSH_STROBE(RX_FLUSH_STROBE),
  .RX_THRESHOLD_LEVEL(RX_THRESHOLD_LEVEL), .DBG_CFG(DBG_CFG), .RX_COUNT(RX_COUNT),
  .RADIO_STATUS(RADIO_STATUS), .FRAME_DELIM_FLAG(FRAME_DELIM_FLAG),
  .RX_THRESHOLD_FLAG(RX_THRESHOLD_FLAG), .RADIO_IRQ(RADIO_IRQ),
  .RADIO_ERROR_IRQ(RADIO_ERROR_IRQ), .DBG_PINS(DBG_PINS));

// file: bench/rfs_core_model.sv
// Core and DMA side model: drains the receive store and issues flushes.
// Assumes the store count and a flush request come from the bench.
`timescale 1ns/100ps
module rfs_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       drain,
  input  wire logic       slow,
  input  wire logic [7:0] count,
  input  wire logic       flush_req,
  output logic            rd,
  output logic            flush
);
  logic [2:0] gap_reg;
  logic [1:0] fl_reg;

  // Pops one byte per gap, slower in slow mode; each flush is sent twice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_reg <= 3'h0;
      fl_reg <= 2'h0;
      rd <= 1'b0;
      flush <= 1'b0;
    end else begin
      rd <= 1'b0;
      flush <= 1'b0;
      if (gap_reg != 3'h0) begin
        gap_reg <= gap_reg - 3'h1;
      end else if (drain && count != 8'h00) begin
        rd <= 1'b1;
        gap_reg <= slow ? 3'h4 : 3'h2; // Count output lags a read by two edges
      end
      if (flush_req) begin
        fl_reg <= 2'h3;
      end else if (fl_reg != 2'h0) begin
        flush <= fl_reg[0];
        fl_reg <= fl_reg - 2'h1;
      end
    end
  end
endmodule

// file: bench/radio_frame_status_sync_tb.sv
// Self-checking bench of the frame status, sync header and length block.
// Assumes rfs_top, the core model and the bound checker are compiled first.
`timescale 1ns/100ps
module radio_frame_status_sync_tb;
  logic                  clk = 1'b0, rst = 1'b1, rx_v = 1'b0, tx_rdy = 1'b0, tx_go = 1'b0;
  logic                  tx_v = 1'b0, chan = 1'b0, err_en = 1'b0, dclr = 1'b0, tclr = 1'b0;
  logic                  sw_ld = 1'b0, pl_ld = 1'b0, drain = 1'b0, slow = 1'b0, fl_req = 1'b0;
  logic [3:0]            rx_s = 4'h0, pl = 4'h6, sym, pins;
  logic [7:0]            tx_d = 8'h00, rx_data, rx_cnt;
  logic [15:0]           sw = 16'ha70f;
  logic [6:0]            thr = 7'h10;
  logic                  ce = 1'b1;
  rfs_pkg::rfs_dbg_cfg_s cfg = '0;
  rfs_pkg::rfs_status_s  st;
  logic                  rd, flush, take, sv, dflag, tflag, irq, eirq, lock = 1'b0;
  logic [7:0]            exp_q[$], tx_q[$];
  logic [3:0]            exp_s[$];
  int                    n_mismatch = 0, check_count = 0, n_err = 0, cycles = 0;
  int                    sym_n = 0, pre_n = 0, e0;

  rfs_top i_dut (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .RX_SYM_VALID(rx_v),
    .RX_SYM(rx_s), .TX_SYM_READY(tx_rdy), .TX_START(tx_go), .TX_DATA_VALID(tx_v),
    .TX_DATA(tx_d), .RX_FLUSH_STROBE(flush), .RX_READ(rd), .CHANNEL_CLEAR(chan),
    .ERR_IRQ_ENABLE(err_en), .DELIM_FLAG_CLEAR(dclr), .THRESH_FLAG_CLEAR(tclr),
    .SYNC_WORD(sw), .SYNC_WORD_LOAD(sw_ld), .PREAMBLE_LENGTH(pl), .PREAMBLE_LOAD(pl_ld),
    .RX_THRESHOLD_LEVEL(thr), .DBG_CFG(cfg), .RX_DATA(rx_data), .RX_COUNT(rx_cnt),
    .TX_DATA_TAKE(take), .TX_SYM_VALID(sv), .TX_SYM(sym), .RADIO_STATUS(st),
    .FRAME_DELIM_FLAG(dflag), .RX_THRESHOLD_FLAG(tflag), .RADIO_IRQ(irq),
    .RADIO_ERROR_IRQ(eirq), .DBG_PINS(pins));
  rfs_core_model i_core (.clk(clk), .rst(rst), .drain(drain), .slow(slow), .count(rx_cnt),
    .flush_req(fl_req), .rd(rd), .flush(flush));

  // Clock of 4 ns
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One received symbol; the line carries junk while not valid
  task automatic sym_in(input logic [3:0] s);
    @(posedge clk);
    rx_v <= 1'b1;
    rx_s <= s;
    @(posedge clk);
    rx_v <= 1'b0;
    rx_s <= ~s;
  endtask

  // Zero symbols, delimiter, length byte and random body, low nibble first
  task automatic rx_frame(input logic [6:0] len);
    logic [7:0] b;
    logic       was_locked;
    was_locked = lock;
    repeat (8) sym_in(4'h0);
    sym_in(4'h7);
    sym_in(4'ha);
    cyc(2);
    if (!was_locked) chk(dflag === 1'b1 && st.delim === 1'b1, "rx delimiter flag");
    b = {1'b0, len};
    for (int i = 0; i <= len; i++) begin
      if (i > 0) b = 8'($urandom);
      sym_in(b[3:0]);
      sym_in(b[7:4]);
      if (!lock && exp_q.size() < 128) exp_q.push_back(b);
      else lock = 1'b1;
    end
    cyc(4);
    if (!lock) chk(tflag === 1'b1 && st.delim === 1'b0, "rx frame end");
  endtask

  task automatic drain_wait();
    for (int t = 0; t < 4000 && exp_q.size() != 0; t++) @(posedge clk);
    cyc(6);
    chk(exp_q.size() == 0 && rx_cnt === 8'h00, "store not drained");
  endtask

  task automatic clear_flags();
    @(posedge clk);
    dclr <= 1'b1;
    tclr <= 1'b1;
    @(posedge clk);
    dclr <= 1'b0;
    tclr <= 1'b0;
    cyc(2);
    chk(dflag === 1'b0, "delimiter flag clear");
  endtask

  // Queues expected symbols of one frame, then starts it and waits
  task automatic tx_frame(input logic [3:0] pre, input logic [15:0] sw_v, input int n_data);
    logic [7:0] b;
    logic [7:0] len;
    len = 8'($urandom_range(3, 20));
    for (int i = 0; i < pre; i++) exp_s.push_back(4'h0);
    for (int i = 0; i < 4; i++) exp_s.push_back(sw_v[4*i +: 4]);
    for (int i = 0; i <= n_data && i <= len; i++) begin
      b = (i == 0) ? len : 8'($urandom);
      tx_q.push_back(b);
      exp_s.push_back(b[3:0]);
      exp_s.push_back(b[7:4]);
    end
    @(posedge clk);
    tx_d <= tx_q[0];
    tx_v <= 1'b1;
    tx_go <= 1'b1;
    sym_n = 0;
    pre_n = pre;
    @(posedge clk);
    tx_go <= 1'b0;
    for (int t = 0; t < 3000 && exp_s.size() != 0; t++) @(posedge clk);
    cyc(30);
    chk(exp_s.size() == 0 && st.delim === 1'b0, "tx frame end");
    tx_q.delete();
    tx_v <= 1'b0;
  endtask

  function automatic logic [3:0] dbg_exp(input rfs_pkg::rfs_dbg_cfg_s c, input logic [3:0] s);
    for (int p = 0; p < 4; p++) dbg_exp[p] = s[3 - c.sel[p]] ^ c.invert[p];
  endfunction

  // Read data, error pulses, transmit feed and symbols
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
    if (rd && exp_q.size() != 0) chk(rx_data === exp_q.pop_front(), "rx byte");
    if (eirq === 1'b1) n_err++;
    tx_rdy <= ($urandom % (slow ? 4 : 1)) == 0;
    if (take && tx_q.size() != 0) begin
      void'(tx_q.pop_front());
      tx_v <= tx_q.size() != 0;
      if (tx_q.size() != 0) tx_d <= tx_q[0];
    end
    if (sv) begin
      if (sym_n == pre_n + 4) chk(dflag === 1'b1 && st.delim === 1'b1, "tx delim");
      if (exp_s.size() != 0) chk(sym === exp_s.pop_front(), "tx symbol");
      else chk(1'b0, "extra tx symbol");
      sym_n++;
    end
  end

  // Main sequence
  initial begin
    void'($urandom(8));
    cyc(20);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      slow <= k[0];
      thr <= 7'($urandom_range(1, 30));
      cfg <= rfs_pkg::rfs_dbg_cfg_s'($urandom);
      drain <= 1'b1;
      rx_frame(7'($urandom_range(k == 0 ? 0 : 1, k == 5 ? 127 : 40)));
      clear_flags();
    end
    drain_wait();
    drain <= 1'b0;
    err_en <= 1'b1;
    e0 = n_err;
    rx_frame(7'h7f);
    rx_frame(7'h03);
    cyc(4);
    chk(n_err != e0 && st.nonempty === 1'b0 && st.threshold === 1'b1, "overflow");
    chk(rx_cnt === 8'h80, "overflow count");
    drain <= 1'b1;
    drain_wait();
    @(posedge clk);
    fl_req <= 1'b1;
    @(posedge clk);
    fl_req <= 1'b0;
    cyc(8);
    lock = 1'b0;
    chk(rx_cnt === 8'h00 && st.delim === 1'b0, "flush recovery");
    drain <= 1'b0;
    rx_frame(7'h03);
    tx_frame(4'h6, 16'ha70f, 127);
    chk(st.nonempty === 1'b1 && rx_cnt === 8'h04, "store status in tx");
    drain <= 1'b1;
    drain_wait();
    pl <= 4'h8;
    sw <= 16'h5b0f;
    pl_ld <= 1'b1;
    sw_ld <= 1'b1;
    @(posedge clk);
    pl_ld <= 1'b0;
    sw_ld <= 1'b0;
    slow <= 1'b1;
    tx_frame(4'h8, 16'h5b0f, 127);
    for (int en = 1; en >= 0; en--) begin
      err_en <= en[0];
      e0 = n_err;
      tx_frame(4'h8, 16'h5b0f, 2);
      chk(n_err == e0 + en, "underflow error irq");
    end
    chan <= 1'b1;
    repeat (4) begin
      cfg <= rfs_pkg::rfs_dbg_cfg_s'($urandom);
      cyc(5);
      chk(pins === dbg_exp(cfg, 4'b0001), "debug pins");
    end
    // Clock enable low freezes the pins although the clear input drops
    ce <= 1'b0;
    chan <= 1'b0;
    cyc(5);
    chk(pins === dbg_exp(cfg, 4'b0001), "frozen by clock enable");
    ce <= 1'b1;
    tally_and_finish();
  end
endmodule
